// >>> rtl/cafc_pkg.sv
// shared constants for the counter array control/flag register
package cafc_pkg;
  localparam logic [7:0] CAFC_REG_ADDR = 8'hd8;
  localparam logic [7:0] CAFC_RESET_VAL = 8'h00;
  localparam int CAFC_BIT_OVF = 7;
  localparam int CAFC_BIT_RUN = 6;
  localparam int CAFC_BIT_M2 = 2;
  localparam int CAFC_BIT_FLAG0 = 0;
  localparam int CAFC_UNUSED_HI = 5;
  localparam int CAFC_UNUSED_LO = 3;
  localparam int CAFC_NUM_MODULES = 3;
endpackage

// >>> rtl/cafc_flags.sv
// control/flag register of the programmable counter array
`timescale 1ns/10ps
module cafc_flags #(
  parameter int NUM_MODULES = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_sel,
  input wire logic counter_wrap,
  input wire logic [NUM_MODULES-1:0] module_event,
  input wire logic overflow_irq_en,
  input wire logic [NUM_MODULES-1:0] module_irq_en,
  input wire logic watchdog_enabled,
  output logic counter_run,
  output logic array_irq,
  output logic watchdog_reset_req
);
  // three flags fill bits 2..0; more would run into the unused field, and the
  // checks below look at module 2 by index
  if (NUM_MODULES != cafc_pkg::CAFC_NUM_MODULES)
  begin : g_bad_modules
    $error("cafc_flags: only three modules fit the register");
  end

  logic reg_wr;
  logic counter_overflow_flag_r;
  logic counter_run_control_r;
  logic [NUM_MODULES-1:0] module_event_flag_r;
  logic [7:0] rdata_nxt;

  // one decode shared by the write strobe, the select output and the read mux
  function automatic logic addr_hit(input logic [7:0] addr);
    return addr == cafc_pkg::CAFC_REG_ADDR;
  endfunction

  assign reg_wr = sfr_wr && addr_hit(sfr_addr);
  assign sfr_sel = addr_hit(sfr_addr);

  // set wins over a simultaneous software clear
  // a write of one leaves the overflow flag alone; only a counter wrap sets it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      counter_overflow_flag_r <= 1'b0;
    else if (clk_en)
    begin
      if (counter_wrap)
        counter_overflow_flag_r <= 1'b1;
      else if (reg_wr && !sfr_wdata[cafc_pkg::CAFC_BIT_OVF])
        counter_overflow_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      module_event_flag_r <= '0;
    else if (clk_en)
    begin
      for (int i = 0; i < NUM_MODULES; i++)
      begin
        if (module_event[i])
          module_event_flag_r[i] <= 1'b1;
        else if (reg_wr && !sfr_wdata[i])
          module_event_flag_r[i] <= 1'b0;
        // a one forces the flag, except flag 2 while the watchdog is on
        else if (reg_wr && sfr_wdata[i] && !(watchdog_enabled && i == cafc_pkg::CAFC_BIT_M2))
          module_event_flag_r[i] <= 1'b1;
      end
    end
  end

  // software's own run setting is kept even while the watchdog overrides it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      counter_run_control_r <= 1'b0;
    else if (clk_en && reg_wr && !watchdog_enabled)
      counter_run_control_r <= sfr_wdata[cafc_pkg::CAFC_BIT_RUN];
  end

  always_ff @(posedge clk)
  begin
    // one-cycle request; the reset logic outside must catch it in that cycle
    if (sys_rst)
      watchdog_reset_req <= 1'b0;
    else if (clk_en)
      watchdog_reset_req <= reg_wr && watchdog_enabled
                            && sfr_wdata[cafc_pkg::CAFC_BIT_M2];
  end

  assign counter_run = counter_run_control_r || watchdog_enabled;
  assign array_irq = (counter_overflow_flag_r && overflow_irq_en)
                     || |(module_event_flag_r & module_irq_en);

  always_comb
  begin
    rdata_nxt = 8'h00;
    rdata_nxt[cafc_pkg::CAFC_BIT_OVF] = counter_overflow_flag_r;
    rdata_nxt[cafc_pkg::CAFC_BIT_RUN] = counter_run_control_r;
    rdata_nxt[cafc_pkg::CAFC_BIT_FLAG0 +: NUM_MODULES] = module_event_flag_r;
  end

  // read data registered; zero when another address is read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sfr_rdata <= cafc_pkg::CAFC_RESET_VAL;
    else if (clk_en && sfr_rd)
      sfr_rdata <= addr_hit(sfr_addr) ? rdata_nxt : 8'h00;
  end

  // watchdog-armed write of one to the module 2 flag
  sequence wd_force_s;
    clk_en && reg_wr && watchdog_enabled && sfr_wdata[cafc_pkg::CAFC_BIT_M2];
  endsequence

  sequence wrap_s;
    clk_en && counter_wrap;
  endsequence

  sequence flag2_event_s;
    clk_en && module_event[2];
  endsequence

  sequence reg_read_s;
    clk_en && sfr_rd && sfr_sel;
  endsequence

  flag_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && module_event_flag_r[0] && !(reg_wr && !sfr_wdata[0])
    |=> module_event_flag_r[0])
    else $error("flag0 dropped without clear");

  flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && reg_wr && !sfr_wdata[1] && !module_event[1]
    |=> !module_event_flag_r[1])
    else $error("zero write did not clear flag1");

  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && module_event[1]
    |=> module_event_flag_r[1])
    else $error("event did not set flag1");

  irq_raise_a: assert property (@(posedge clk) disable iff (sys_rst)
    flag2_event_s ##1 module_irq_en[2]
    |-> array_irq)
    else $error("irq missing for flag2");

  ovf_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrap_s ##1 overflow_irq_en
    |-> array_irq)
    else $error("irq missing for overflow");

  wd_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    wd_force_s
    |=> watchdog_reset_req)
    else $error("watchdog reset not requested");

  wd_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !(reg_wr && watchdog_enabled && sfr_wdata[cafc_pkg::CAFC_BIT_M2])
    |=> !watchdog_reset_req)
    else $error("watchdog reset request without write");

  wd_no_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    wd_force_s ##0 (!module_event[2] && !module_event_flag_r[2])
    |=> !module_event_flag_r[2])
    else $error("flag2 set by watchdog reset write");

  run_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && watchdog_enabled
    |=> $stable(counter_run_control_r))
    else $error("run bit changed under watchdog");

  run_forced_a: assert property (@(posedge clk) disable iff (sys_rst)
    watchdog_enabled
    |-> counter_run)
    else $error("counter not forced on by watchdog");

  run_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_read_s
    |=> sfr_rdata[cafc_pkg::CAFC_BIT_RUN] == $past(counter_run_control_r))
    else $error("run bit read wrong");

  unused_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_rdata[cafc_pkg::CAFC_UNUSED_HI:cafc_pkg::CAFC_UNUSED_LO] == 3'h0)
    else $error("unused bits not zero");

  ovf_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrap_s
    |=> counter_overflow_flag_r ##0 sfr_rdata[4] == 1'b0)
    else $error("overflow flag not set");

  ovf_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && counter_overflow_flag_r && !(reg_wr && !sfr_wdata[cafc_pkg::CAFC_BIT_OVF])
    |=> counter_overflow_flag_r)
    else $error("overflow flag dropped without clear");

  bit_place_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_read_s
    |=> sfr_rdata[2:0] == $past(module_event_flag_r))
    else $error("flag bit placement wrong");

  state_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en
    |=> $stable(module_event_flag_r) && $stable(counter_overflow_flag_r))
    else $error("state moved while clock enable low");
endmodule

// >>> dv/cafc_cpu_model.sv
// cpu side of the sfr bus, one byte per transfer
`timescale 1ns/10ps
module cafc_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial {wr, rd, addr, wdata} = '0;
  // released lines flip so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    #5 {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk);
    #5 q = rdata;
    {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the counter array control/flag register
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module testbench;
  localparam logic [7:0] A = cafc_pkg::CAFC_REG_ADDR;
  logic clk = 0, sys_rst = 1, wrap = 0, ovf_en = 0, wd = 0, ce = 1;
  logic [2:0] ev = 0, irq_en = 0;
  logic wr, rd, sel, run, irq, wdr;
  logic [7:0] addr, wdata, rdata, q;
  int n_fail = 0, num_checks = 0;
  always #25 clk = ~clk;
  cafc_cpu_model cpu (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  cafc_flags uut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_addr(addr), .sfr_wdata(wdata), .sfr_rdata(rdata), .sfr_sel(sel),
    .counter_wrap(wrap), .module_event(ev), .overflow_irq_en(ovf_en),
    .module_irq_en(irq_en), .watchdog_enabled(wd), .counter_run(run),
    .array_irq(irq), .watchdog_reset_req(wdr));
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    fork
      cpu.xfer(0, a, 8'h00, q);
      begin
        @(posedge clk);
        #10 `CHK(sel, a == A)
      end
    join
    `CHK(q, e)
  endtask
  task automatic t_flags();
    @(posedge clk);
    #5 {ev, wrap} = 4'hb;
    @(posedge clk);
    #5 {ev, wrap} = 4'h0;
    `CHK(irq, 1'b0)
    irq_en = 3'h4;
    #1 `CHK(irq, 1'b1)
    irq_en = 3'h0;
    ovf_en = 1;
    #1 `CHK(irq, 1'b1)
    irq_en = 3'h4;
    rd_chk(A, 8'h85);
    cpu.xfer(1, A, 8'hfd, q);
    rd_chk(A, 8'hc5);
    `CHK(run, 1'b1)
    rd_chk(8'hd9, 8'h00);
    cpu.xfer(1, A, 8'h00, q);
    rd_chk(A, 8'h00);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_wd();
    wd = 1;
    #1 `CHK(run, 1'b1)
    rd_chk(A, 8'h00);
    cpu.xfer(1, A, 8'h44, q);
    `CHK(wdr, 1'b1)
    rd_chk(A, 8'h00);
    `CHK(wdr, 1'b0)
    wd = 0;
    #1 `CHK(run, 1'b0)
  endtask
  task automatic t_reset();
    irq_en = 3'h7;
    @(posedge clk);
    #5 {ev, wrap} = 4'hf;
    @(posedge clk);
    #5 {ev, wrap} = 4'h0;
    `CHK(irq, 1'b1)
    cpu.xfer(1, A, 8'hc7, q);
    rd_chk(A, 8'hc7);
    `CHK(run, 1'b1)
    sys_rst = 1;
    repeat (2) @(posedge clk);
    #5 sys_rst = 0;
    `CHK(rdata, 8'h00)
    `CHK(irq, 1'b0)
    `CHK(run, 1'b0)
    `CHK(wdr, 1'b0)
    rd_chk(A, 8'h00);
  endtask
  task automatic t_freeze();
    @(posedge clk);
    #5 ce = 0;
    {ev, wrap} = 4'h5;
    @(posedge clk);
    #5 {ev, wrap} = 4'h0;
    ce = 1;
    `CHK(irq, 1'b0)
    rd_chk(A, 8'h00);
  endtask
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    #5 sys_rst = 0;
    `CHK(run, 1'b0)
    rd_chk(A, 8'h00);
    t_flags();
    t_wd();
    t_reset();
    t_freeze();
    final_report();
  end
endmodule
